/* File: hdl/supply_monitor_map.svh */
`ifndef SUPPLY_MONITOR_MAP_SVH
`define SUPPLY_MONITOR_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_MODE_CTRL      6'h00
`define IDX_TRIP_CTRL      6'h01
`define IDX_WARN_LEVEL     6'h08
`define IDX_WARN_IRQ_CTRL  6'h09
`define IDX_WARN_IRQ_FLAGS 6'h0a
`define IDX_WARN_STATE     6'h0b
`define IDX_UNLOCK         6'h0f

// Field positions
`define FLD_SLEEP_LO       3'h0
`define FLD_ACTIVE_LO      3'h2
`define FLD_RATE           3'h4
`define FLD_IRQ_EN         3'h0
`define FLD_DIR_LO         3'h1

// Mode codes of the awake and low-power fields
`define MODE_OFF           2'h0
`define MODE_ON            2'h1
`define MODE_SAMPLED       2'h2
`define MODE_ON_HOLD       2'h3

// Warning direction codes
`define DIR_FALLING        2'h0
`define DIR_RISING         2'h1
`define DIR_EITHER         2'h2

// Trip level codes
`define TRIP_CODE_LOW      3'h2
`define TRIP_CODE_HIGH     3'h7

// Unlock key (arbitrary value) and window in bus transfers
`define IO_UNLOCK_KEY      8'h5a
`define UNLOCK_WINDOW      3'h4

// Reset values of software registers
`define RST_MARGIN         2'h0
`define RST_DIR            2'h0

// Timing: sample periods in microseconds, clock in MHz
`define SAMPLE_FAST_US     32'h3e8
`define SAMPLE_SLOW_US     32'h1f40
`define CLK_MHZ            32'h32

`endif

/* File: hdl/supply_monitor_pkg.sv */
package supply_monitor_pkg;

  typedef struct packed {
    logic       rate;
    logic [1:0] active;
    logic [1:0] sleep;
    logic [2:0] trip;
  } fuse_cfg_s;

  typedef struct packed {
    logic        load_pend;
    logic [1:0]  active_sel;
    logic [1:0]  sleep_sel;
    logic        rate_sel;
    logic [2:0]  trip;
    logic [1:0]  margin;
    logic [1:0]  dir;
    logic        ie;
    logic        flag;
    logic        warn_state;
    logic        bod_state;
    logic [2:0]  warn_sync;
    logic [2:0]  bod_sync;
    logic [2:0]  ready_sync;
    logic        warn_in;
    logic        bod_in;
    logic        ready_in;
    logic [2:0]  unlock_cnt;
    logic        deep_q;
    logic        wake_hold;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic        rst_req;
    logic        mon_on;
    logic        warn_on;
  } mon_state_s;

endpackage

/* File: hdl/sample_strobe_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module sample_strobe_gen #(
  parameter int FAST_CYC = 50000,
  parameter int SLOW_CYC = 400000
) (
  input  wire logic clk_i,    // System clock
  input  wire logic arst_n_i, // Async reset, active low
  input  wire logic run_i,    // Sampled mode active
  input  wire logic slow_i,   // Select slow rate
  output logic      strobe_o  // One-cycle compare enable
);

  typedef struct packed {
    logic [18:0] cnt;
    logic        strobe;
  } strobe_state_s;

  strobe_state_s st;
  strobe_state_s next_st;
  logic [18:0]   last;

  always_comb begin
    next_st = st;
    last = slow_i ? 19'(SLOW_CYC - 1) : 19'(FAST_CYC - 1);
    next_st.strobe = 1'b0;
    if (!run_i) begin
      next_st.cnt = 19'h0;
    end else if (st.cnt >= last) begin
      // Compare enable once per period
      next_st.cnt = 19'h0;
      next_st.strobe = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 19'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign strobe_o = st.strobe;

endmodule
`default_nettype wire

/* File: hdl/supply_monitor_control.sv */
// Summary of operation
// - Reset loads rate, mode and trip settings from fuses; margin and direction from fixed values
// - Trip level and awake mode fuse-only
// - Enable bit turns on warning function
// - Monitor off keeps warning inactive
// - Sampled monitor samples warning at same instants
// - Enabling with either-direction sets flag while monitor on
// - Sampled mode: only direction 0x1 triggers
// - Margin field 5/15/25 percent above trip
// - Warning condition sets flag regardless of enable
// - Request while flag and enable both set
// - Debug halt leaves monitor behaviour unchanged
// - Deep sleep uses low-power mode, wake awake
// - Low-power field writable, awake field read-only
// - Protected write needs key within four transfers
// - Rate bit: 1 kHz or 125 Hz
// - Awake field: off, on, sampled, hold
// - Low-power field: off, on, sampled, reserved
// - Three-bit fuse trip level, upper bits zero
// - Direction: falling, rising, either, reserved
// - Flag sets only while monitor enabled
// - State bit reads one when below warning
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "supply_monitor_map.svh"
module supply_monitor_control #(
  parameter int SAMPLE_FAST_CYC = `SAMPLE_FAST_US * `CLK_MHZ,
  parameter int SAMPLE_SLOW_CYC = `SAMPLE_SLOW_US * `CLK_MHZ
) (
  input  wire logic                           clk_i,         // 50 MHz clock
  input  wire logic                           arst_n_i,      // Async reset, active low
  input  wire supply_monitor_pkg::fuse_cfg_s  fuse_i,        // Static fuse values
  input  wire logic                           psel,          // APB select
  input  wire logic                           penable,       // APB enable
  input  wire logic                           pwrite,        // APB direction
  input  wire logic [7:0]                     paddr,         // APB byte address
  input  wire logic [31:0]                    pwdata,        // APB write data
  output logic      [31:0]                    prdata,        // APB read data
  output logic                                pready,        // APB ready
  output logic                                pslverr,       // APB error
  input  wire logic                           sleep_deep_i,  // Standby or power-down
  input  wire logic                           bod_below_i,   // Supply below trip level
  input  wire logic                           warn_below_i,  // Supply below warning level
  input  wire logic                           bod_ready_i,   // Analog monitor settled
  output logic      [2:0]                     trip_level_o,  // Trip code to analog
  output logic      [1:0]                     margin_sel_o,  // Warning margin code
  output logic                                monitor_on_o,  // Analog monitor enable
  output logic                                warn_on_o,     // Warning comparator enable
  output logic                                wake_hold_o,   // Hold wake-up until ready
  output logic                                reset_req_o,   // Brown-out reset request
  output logic                                irq_o          // Warning interrupt
);

  supply_monitor_pkg::mon_state_s st;
  supply_monitor_pkg::mon_state_s next_st;

  logic       strobe;
  logic [1:0] cur_mode;
  logic       mon_en;
  logic       sampled;
  logic       cmp_en;
  logic       commit;
  logic       wr;
  logic [5:0] idx;
  logic       mapped;
  logic       went_below;
  logic       went_above;
  logic       trig;

  // Low-power selection only in deep sleep; awake selection otherwise
  always_comb begin
    cur_mode = sleep_deep_i ? st.sleep_sel : st.active_sel;
  end

  // Reserved low-power code counts as off
  assign mon_en  = !st.load_pend && (cur_mode != `MODE_OFF)
                   && !(sleep_deep_i && cur_mode == `MODE_ON_HOLD);
  assign sampled = mon_en && (cur_mode == `MODE_SAMPLED);

  sample_strobe_gen #(
    .FAST_CYC (SAMPLE_FAST_CYC),
    .SLOW_CYC (SAMPLE_SLOW_CYC)
  ) u_strobe (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .run_i    (sampled),
    .slow_i   (st.rate_sel),
    .strobe_o (strobe)
  );

  // Both comparators share one compare enable
  assign cmp_en = mon_en && (!sampled || strobe);

  assign commit = psel && penable && st.pready;
  assign wr     = commit && pwrite;
  assign idx    = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'h0)
                  && (idx == `IDX_MODE_CTRL || idx == `IDX_TRIP_CTRL
                      || idx == `IDX_WARN_LEVEL || idx == `IDX_WARN_IRQ_CTRL
                      || idx == `IDX_WARN_IRQ_FLAGS || idx == `IDX_WARN_STATE
                      || idx == `IDX_UNLOCK);

  assign went_below = cmp_en && st.warn_in && !st.warn_state;
  assign went_above = cmp_en && !st.warn_in && st.warn_state;

  // Sampled mode can only see one direction reliably
  always_comb begin
    if (sampled) begin
      trig = (st.dir == `DIR_RISING) && went_above;
    end else begin
      case (st.dir)
        `DIR_FALLING: trig = went_below;
        `DIR_RISING:  trig = went_above;
        `DIR_EITHER:  trig = went_below || went_above;
        default:      trig = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_st = st;

    // Pin synchronisers: change accepted when stages two and three agree
    next_st.warn_sync  = {st.warn_sync[1:0], warn_below_i};
    next_st.bod_sync   = {st.bod_sync[1:0], bod_below_i};
    next_st.ready_sync = {st.ready_sync[1:0], bod_ready_i};
    if (st.warn_sync[1] == st.warn_sync[2]) begin
      next_st.warn_in = st.warn_sync[2];
    end
    if (st.bod_sync[1] == st.bod_sync[2]) begin
      next_st.bod_in = st.bod_sync[2];
    end
    if (st.ready_sync[1] == st.ready_sync[2]) begin
      next_st.ready_in = st.ready_sync[2];
    end

    // Fuse capture in the first cycle after reset release
    if (st.load_pend) begin
      next_st.load_pend  = 1'b0;
      next_st.rate_sel   = fuse_i.rate;
      next_st.active_sel = fuse_i.active;
      next_st.sleep_sel  = fuse_i.sleep;
      next_st.trip       = fuse_i.trip;
    end

    // Comparator results are latched only on compare enable
    if (cmp_en) begin
      next_st.warn_state = st.warn_in;
      next_st.bod_state  = st.bod_in;
    end

    // Unlock window counts completed bus transfers
    if (commit && st.unlock_cnt != 3'h0) begin
      next_st.unlock_cnt = st.unlock_cnt - 3'h1;
    end

    next_st.pslverr = 1'b0;
    next_st.prdata  = 32'h0;
    if (wr && mapped) begin
      case (idx)
        `IDX_MODE_CTRL: begin
          // Awake field and rate bit ignore writes
          if (st.unlock_cnt != 3'h0) begin
            next_st.sleep_sel  = pwdata[`FLD_SLEEP_LO +: 2];
            next_st.unlock_cnt = 3'h0;
          end
        end
        `IDX_WARN_LEVEL: begin
          next_st.margin = pwdata[1:0];
        end
        `IDX_WARN_IRQ_CTRL: begin
          next_st.ie  = pwdata[`FLD_IRQ_EN];
          next_st.dir = pwdata[`FLD_DIR_LO +: 2];
        end
        `IDX_UNLOCK: begin
          if (pwdata[7:0] == `IO_UNLOCK_KEY) begin
            next_st.unlock_cnt = `UNLOCK_WINDOW;
          end
        end
        default: begin
        end
      endcase
    end

    // Write-one-to-clear; a new trigger in the same cycle wins
    if (wr && mapped && idx == `IDX_WARN_IRQ_FLAGS && pwdata[0]) begin
      next_st.flag = 1'b0;
    end
    // Debug halt has no input here, so flags keep running
    if (trig) begin
      next_st.flag = 1'b1;
    end
    if (wr && mapped && idx == `IDX_WARN_IRQ_CTRL && mon_en && !st.ie
        && pwdata[`FLD_IRQ_EN] && pwdata[`FLD_DIR_LO +: 2] == `DIR_EITHER) begin
      next_st.flag = 1'b1;
    end

    if (psel && penable && !st.pready) begin
      next_st.pslverr = !mapped;
      if (!pwrite) begin
        case (idx)
          `IDX_MODE_CTRL: begin
            next_st.prdata[`FLD_RATE]          = st.rate_sel;
            next_st.prdata[`FLD_ACTIVE_LO +: 2] = st.active_sel;
            next_st.prdata[`FLD_SLEEP_LO +: 2]  = st.sleep_sel;
          end
          `IDX_TRIP_CTRL:      next_st.prdata[2:0] = st.trip;
          `IDX_WARN_LEVEL:     next_st.prdata[1:0] = st.margin;
          `IDX_WARN_IRQ_CTRL: begin
            next_st.prdata[`FLD_IRQ_EN]        = st.ie;
            next_st.prdata[`FLD_DIR_LO +: 2]   = st.dir;
          end
          `IDX_WARN_IRQ_FLAGS: next_st.prdata[0] = st.flag;
          `IDX_WARN_STATE:     next_st.prdata[0] = st.warn_state;
          default:             next_st.prdata = 32'h0;
        endcase
        if (!mapped) begin
          next_st.prdata = 32'h0;
        end
      end
    end
    // One wait state: ready in the second access cycle
    next_st.pready = psel && penable && !st.pready;

    // Awake hold after deep sleep until the monitor settles
    next_st.deep_q = sleep_deep_i;
    if (st.deep_q && !sleep_deep_i && st.active_sel == `MODE_ON_HOLD) begin
      next_st.wake_hold = 1'b1;
    end else if (st.ready_in) begin
      next_st.wake_hold = 1'b0;
    end

    next_st.mon_on  = mon_en;
    next_st.warn_on = mon_en && next_st.ie;
    next_st.rst_req = mon_en && next_st.bod_state;
    next_st.irq     = next_st.flag && next_st.ie;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st           <= '0;
      st.load_pend <= 1'b1;
      st.margin    <= `RST_MARGIN;
      st.dir       <= `RST_DIR;
    end else begin
      st <= next_st;
    end
  end

  assign prdata       = st.prdata;
  assign pready       = st.pready;
  assign pslverr      = st.pslverr;
  assign trip_level_o = st.trip;
  assign margin_sel_o = st.margin;
  assign monitor_on_o = st.mon_on;
  assign warn_on_o    = st.warn_on;
  assign wake_hold_o  = st.wake_hold;
  assign reset_req_o  = st.rst_req;
  assign irq_o        = st.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_wait;
    psel && penable && !pready;
  endsequence

  a_apb_one_wait: assert property (s_apb_setup ##1 s_apb_wait |=> pready)
    else $error("ready not given after one wait state");

  a_fuse_load_cap: assert property (st.load_pend |=> st.trip == $past(fuse_i.trip)
                                     && st.active_sel == $past(fuse_i.active))
    else $error("fuse values not captured after reset");

  a_awake_fixed: assert property (!st.load_pend && !$past(st.load_pend)
                                  |-> $stable(st.active_sel) && $stable(st.trip))
    else $error("fuse-only field changed");

  a_locked_sleep: assert property (wr && idx == `IDX_MODE_CTRL && st.unlock_cnt == 3'h0
                                   |=> $stable(st.sleep_sel))
    else $error("low-power field changed without unlock");

  a_unlocked_sleep: assert property (wr && idx == `IDX_MODE_CTRL && st.unlock_cnt != 3'h0
                                     && !st.load_pend && mapped
                                     |=> st.sleep_sel == $past(pwdata[1:0]))
    else $error("unlocked low-power write lost");

  a_sample_hold: assert property (sampled && !strobe |=> $stable(st.warn_state))
    else $error("warning state moved between samples");

  a_off_no_flag: assert property (!mon_en && !st.flag |=> !st.flag)
    else $error("flag set while monitor off");

  a_irq_pair: assert property (irq_o == (st.flag && st.ie))
    else $error("request does not match flag and enable");

  a_reset_cause: assert property ($rose(reset_req_o) |-> $past(mon_en) && st.bod_state)
    else $error("reset request without enabled brown-out");

  // Bus response, flag, enable, wake-up hold and unlock behaviour
  sequence s_either_enable;
    wr && mapped && idx == `IDX_WARN_IRQ_CTRL && mon_en && !st.ie
    && pwdata[`FLD_IRQ_EN] && pwdata[`FLD_DIR_LO +: 2] == `DIR_EITHER;
  endsequence

  sequence s_hold_wake;
    st.deep_q && !sleep_deep_i && st.active_sel == `MODE_ON_HOLD;
  endsequence

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match address decode");

  a_flag_set: assert property (trig |=> st.flag)
    else $error("trigger did not set flag");

  a_flag_clear: assert property (wr && mapped && idx == `IDX_WARN_IRQ_FLAGS
                                 && pwdata[0] && !trig |=> !st.flag)
    else $error("flag not cleared by write of one");

  a_either_arms: assert property (s_either_enable |=> st.flag)
    else $error("either-direction enable did not set flag");

  a_sampled_dir: assert property (sampled && st.dir != `DIR_RISING |-> !trig)
    else $error("sampled mode triggered on wrong direction");

  a_warn_gate: assert property (!mon_en |=> !warn_on_o)
    else $error("warning enabled while monitor off");

  a_hold_on_wake: assert property (s_hold_wake |=> wake_hold_o)
    else $error("wake-up hold missing after deep sleep");

  a_hold_release: assert property (wake_hold_o && st.ready_in
                                   && !(st.deep_q && !sleep_deep_i) |=> !wake_hold_o)
    else $error("wake-up hold kept after monitor ready");

  a_unlock_arm: assert property (wr && mapped && idx == `IDX_UNLOCK
                                 && pwdata[7:0] == `IO_UNLOCK_KEY
                                 |=> st.unlock_cnt == `UNLOCK_WINDOW)
    else $error("unlock key did not open the window");

endmodule
`default_nettype wire

/* File: tb/supply_monitor_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "supply_monitor_map.svh"
module supply_monitor_control_tb;
  localparam logic [7:0] A_MODE  = {`IDX_MODE_CTRL, 2'b00};
  localparam logic [7:0] A_TRIP  = {`IDX_TRIP_CTRL, 2'b00};
  localparam logic [7:0] A_WLVL  = {`IDX_WARN_LEVEL, 2'b00};
  localparam logic [7:0] A_ICTRL = {`IDX_WARN_IRQ_CTRL, 2'b00};
  localparam logic [7:0] A_FLAGS = {`IDX_WARN_IRQ_FLAGS, 2'b00};
  localparam logic [7:0] A_STATE = {`IDX_WARN_STATE, 2'b00};
  localparam logic [7:0] A_UNLK  = {`IDX_UNLOCK, 2'b00};

  logic                          clk_i = 1'b0;
  logic                          arst_n_i = 1'b0;
  supply_monitor_pkg::fuse_cfg_s fuse_i = '0;
  logic                          psel = 1'b0;
  logic                          penable = 1'b0;
  logic                          pwrite = 1'b0;
  logic [7:0]                    paddr = 8'h00;
  logic [31:0]                   pwdata = 32'h0;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          sleep_deep_i = 1'b0;
  logic                          bod_below_i = 1'b0;
  logic                          warn_below_i = 1'b0;
  logic                          bod_ready_i = 1'b1;
  logic [2:0]                    trip_level_o;
  logic [1:0]                    margin_sel_o;
  logic                          monitor_on_o;
  logic                          warn_on_o;
  logic                          wake_hold_o;
  logic                          reset_req_o;
  logic                          irq_o;
  int                            n_fail = 0;
  int                            n_compared = 0;
  int                            cyc = 0;
  int                            seed = 72484;
  logic [31:0]                   rd;
  logic                          er;

  // Short sample periods keep sampled-mode runs brief
  supply_monitor_control #(.SAMPLE_FAST_CYC(20), .SAMPLE_SLOW_CYC(50)) supply_monitor_control_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .fuse_i(fuse_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_deep_i(sleep_deep_i), .bod_below_i(bod_below_i),
    .warn_below_i(warn_below_i), .bod_ready_i(bod_ready_i), .trip_level_o(trip_level_o),
    .margin_sel_o(margin_sel_o), .monitor_on_o(monitor_on_o), .warn_on_o(warn_on_o),
    .wake_hold_o(wake_hold_o), .reset_req_o(reset_req_o), .irq_o(irq_o)
  );

  always #10 clk_i = ~clk_i;

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic do_reset(input supply_monitor_pkg::fuse_cfg_s f);
    @(posedge clk_i);
    arst_n_i     <= 1'b0;
    fuse_i       <= f;
    warn_below_i <= 1'b0;
    bod_below_i  <= 1'b0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  // Covers the three-flop input synchroniser plus flag latency
  task automatic set_warn(input logic v);
    @(posedge clk_i);
    warn_below_i <= v;
    repeat (12) @(posedge clk_i);
  endtask

  function automatic logic [31:0] mode_word(input supply_monitor_pkg::fuse_cfg_s f,
                                            input logic [1:0] sl);
    return {27'h0, f.rate, f.active, sl};
  endfunction

  function automatic logic exp_flag(input logic [1:0] dir, input logic below);
    return dir == `DIR_EITHER || (below ? dir == `DIR_FALLING : dir == `DIR_RISING);
  endfunction

  initial begin
    supply_monitor_pkg::fuse_cfg_s f;
    logic [1:0]                    sl;
    logic [1:0]                    mg;
    int                            k;
    f = '{rate: 1'b0, active: `MODE_ON, sleep: `MODE_OFF, trip: `TRIP_CODE_LOW};
    sl = f.sleep;
    do_reset(f);
    rdc("mode_ctrl", A_MODE, mode_word(f, sl));
    rdc("trip_level", A_TRIP, {29'h0, f.trip});
    chk("trip_level_o", {29'h0, trip_level_o}, {29'h0, f.trip});
    rdc("warn_level", A_WLVL, {30'h0, `RST_MARGIN});
    rdc("irq_ctrl", A_ICTRL, 32'h0);
    // Unprotected write: read-only fields and sleep field stay put
    wr(A_MODE, {$random(seed)} & 32'hffffffe0 | {27'h0, ~f.rate, ~f.active, 2'h2});
    rdc("mode_ctrl", A_MODE, mode_word(f, sl));
    wr(A_TRIP, {29'h0, ~f.trip});
    rdc("trip_level", A_TRIP, {29'h0, f.trip});
    // Unlock window: fourth transfer still accepted, fifth is not
    for (k = 3; k <= 4; k++) begin
      wr(A_UNLK, {24'h0, `IO_UNLOCK_KEY});
      repeat (k) apb(1'b0, A_WLVL, 32'h0);
      wr(A_MODE, {27'h0, ~f.rate, ~f.active, (k == 3) ? `MODE_SAMPLED : `MODE_ON});
      if (k == 3) sl = `MODE_SAMPLED;
      rdc("mode_ctrl", A_MODE, mode_word(f, sl));
    end
    wr(A_UNLK, {24'h0, `IO_UNLOCK_KEY});
    wr(A_MODE, {27'h0, f.rate, f.active, `MODE_OFF});
    rdc("mode_ctrl", A_MODE, mode_word(f, `MODE_OFF));
    chk("monitor_on", monitor_on_o, 1'b1);
    @(posedge clk_i);
    sleep_deep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("monitor_on", monitor_on_o, 1'b0);
    sleep_deep_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("monitor_on", monitor_on_o, 1'b1);
    // Unmapped and misaligned accesses
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", er, 1'b1);
    chk("prdata", rd, 32'h0);
    apb(1'b1, 8'h21, 32'h3);
    chk("pslverr", er, 1'b1);
    rdc("warn_level", A_WLVL, 32'h0);
    repeat (4) begin
      mg = 2'($unsigned($random(seed)) % 3);
      wr(A_WLVL, {$random(seed)} & 32'hfffffffc | {30'h0, mg});
      rdc("warn_level", A_WLVL, {30'h0, mg});
      chk("margin_sel", {30'h0, margin_sel_o}, {30'h0, mg});
    end
    // Falling, rising and either direction codes, enable off
    for (k = 0; k < 3; k++) begin
      wr(A_ICTRL, {29'h0, 2'(k), 1'b0});
      wr(A_FLAGS, 32'h1);
      set_warn(1'b1);
      rdc("flag", A_FLAGS, {31'h0, exp_flag(2'(k), 1'b1)});
      rdc("state", A_STATE, 32'h1);
      chk("irq", irq_o, 1'b0);
      wr(A_FLAGS, 32'h1);
      set_warn(1'b0);
      rdc("flag", A_FLAGS, {31'h0, exp_flag(2'(k), 1'b0)});
      rdc("state", A_STATE, 32'h0);
    end
    wr(A_FLAGS, 32'h1);
    wr(A_ICTRL, {29'h0, `DIR_FALLING, 1'b1});
    set_warn(1'b1);
    chk("warn_on", warn_on_o, 1'b1);
    chk("irq", irq_o, 1'b1);
    wr(A_FLAGS, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("irq", irq_o, 1'b0);
    set_warn(1'b0);
    wr(A_ICTRL, 32'h0);
    wr(A_FLAGS, 32'h1);
    wr(A_ICTRL, {29'h0, `DIR_EITHER, 1'b1});
    repeat (3) @(posedge clk_i);
    rdc("flag", A_FLAGS, 32'h1);
    chk("irq", irq_o, 1'b1);
    @(posedge clk_i);
    bod_below_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk("reset_req", reset_req_o, 1'b1);
    bod_below_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk("reset_req", reset_req_o, 1'b0);
    // Monitor disabled by fuse
    f = '{rate: 1'b1, active: `MODE_OFF, sleep: `MODE_SAMPLED, trip: `TRIP_CODE_HIGH};
    do_reset(f);
    rdc("mode_ctrl", A_MODE, mode_word(f, f.sleep));
    rdc("trip_level", A_TRIP, {29'h0, f.trip});
    wr(A_ICTRL, {29'h0, `DIR_EITHER, 1'b1});
    bod_below_i <= 1'b1;
    set_warn(1'b1);
    chk("warn_on", warn_on_o, 1'b0);
    chk("monitor_on", monitor_on_o, 1'b0);
    rdc("flag", A_FLAGS, 32'h0);
    chk("irq", irq_o, 1'b0);
    chk("reset_req", reset_req_o, 1'b0);
    // Deep sleep switches to sampled mode at the slow rate
    sleep_deep_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    rdc("state", A_STATE, 32'h0);
    repeat (30) @(posedge clk_i);
    rdc("state", A_STATE, 32'h1);
    rdc("flag", A_FLAGS, 32'h0);
    chk("monitor_on", monitor_on_o, 1'b1);
    chk("reset_req", reset_req_o, 1'b1);
    sleep_deep_i <= 1'b0;
    // Sampled mode at the fast rate
    f = '{rate: 1'b0, active: `MODE_SAMPLED, sleep: `MODE_OFF, trip: `TRIP_CODE_LOW};
    do_reset(f);
    wr(A_ICTRL, {29'h0, `DIR_FALLING, 1'b1});
    set_warn(1'b1);
    repeat (60) @(posedge clk_i);
    rdc("flag", A_FLAGS, 32'h0);
    rdc("state", A_STATE, 32'h1);
    wr(A_ICTRL, {29'h0, `DIR_RISING, 1'b1});
    set_warn(1'b0);
    repeat (60) @(posedge clk_i);
    rdc("flag", A_FLAGS, 32'h1);
    chk("irq", irq_o, 1'b1);
    // Wake-up hold in the awake hold mode, then reserved low-power code
    f = '{rate: 1'b0, active: `MODE_ON_HOLD, sleep: `MODE_ON, trip: `TRIP_CODE_HIGH};
    do_reset(f);
    bod_ready_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    sleep_deep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("monitor_on", monitor_on_o, 1'b1);
    chk("wake_hold", wake_hold_o, 1'b0);
    sleep_deep_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("wake_hold", wake_hold_o, 1'b1);
    chk("monitor_on", monitor_on_o, 1'b1);
    bod_ready_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk("wake_hold", wake_hold_o, 1'b0);
    wr(A_UNLK, {24'h0, `IO_UNLOCK_KEY});
    wr(A_MODE, {27'h0, f.rate, f.active, 2'h3});
    rdc("mode_ctrl", A_MODE, mode_word(f, 2'h3));
    sleep_deep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("monitor_on", monitor_on_o, 1'b0);
    sleep_deep_i <= 1'b0;
    conclude();
  end
endmodule
`default_nettype wire
